// ### verilog/ope_pkg.sv
package ope_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int OPE_ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FORMAT = 8'h04;
    localparam logic [7:0] OFS_GAP = 8'h08;
    localparam logic [7:0] OFS_REPEAT = 8'h0C;
    localparam logic [7:0] OFS_PRE_SIZE = 8'h10;
    localparam logic [7:0] OFS_SYNC_SIZE = 8'h14;
    localparam logic [7:0] OFS_SYNC_VALUE = 8'h18;
    localparam logic [7:0] OFS_ID_SIZE = 8'h1C;
    localparam logic [7:0] OFS_ID_VALUE = 8'h20;
    localparam logic [7:0] OFS_STOP = 8'h24;
    localparam logic [7:0] OFS_KEY_SIZE = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_CODE_BASE = 8'h40;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SCAN_BIT = 1;
    localparam int CTRL_PRE_EVERY_BIT = 2;
    localparam int CTRL_PRE_AA_BIT = 3;
    localparam int FMT_LSB = 0;
    localparam int PAT1_LSB = 8;
    localparam int PAT0_LSB = 16;
    localparam int CYC_LSB = 0;
    localparam int PKTN_LSB = 16;
    localparam int STOP_SZ_LSB = 0;
    localparam int STOP_VAL_LSB = 16;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [3:0] RST_BIT_FMT = 4'h4;
    localparam logic [7:0] RST_PAT1 = 8'h0E;
    localparam logic [7:0] RST_PAT0 = 8'h08;
    localparam logic [8:0] RST_PKT_NUM = 9'h002;
    localparam logic [5:0] RST_SYNC_SIZE = 6'h20;
    localparam logic [31:0] RST_SYNC_VAL = 32'h8000_0000;
    localparam logic [3:0] RST_KEY_SIZE = 4'h4;
    localparam logic RST_PRE_EVERY = 1'b1;
    localparam logic [8:0] MAX_COUNT = 9'h100;
    localparam logic [8:0] MAX_BIT_FMT = 9'h008;
    localparam logic [8:0] MAX_WORD_BITS = 9'h020;
    localparam logic [8:0] MAX_STOP_BITS = 9'h010;
    localparam logic [8:0] MAX_KEY_BITS = 9'h008;
    localparam logic [7:0] PRE_BYTE_A = 8'h55;
    localparam logic [7:0] PRE_BYTE_B = 8'hAA;

    // ----------------------------------------------------------------
    // Packet fields in transmit order
    // ----------------------------------------------------------------
    localparam logic [2:0] F_PRE = 3'h0;
    localparam logic [2:0] F_SYNC = 3'h1;
    localparam logic [2:0] F_ID = 3'h2;
    localparam logic [2:0] F_KEY = 3'h3;
    localparam logic [2:0] F_STOP = 3'h4;
    localparam logic [2:0] F_END = 3'h5;

    typedef enum logic [1:0] {S_IDLE, S_FIELD, S_GAP} ope_fsm_t;

    // Clamps a written count into 0..max so odd writes stay in range.
    function automatic logic [8:0] ope_clamp(input logic [31:0] v,
                                             input logic [8:0] max);
        ope_clamp = (v > {23'h0, max}) ? max : v[8:0];
    endfunction : ope_clamp

endpackage : ope_pkg

// ### verilog/ope_sym_buf.sv
module ope_sym_buf
    import ope_pkg::*;
#(
    parameter int W = 2,
    parameter int DEPTH = 2
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0] vld;
    } ope_buf_t;

    ope_buf_t s, n;

    // Entry 0 is the head, so the outputs are taken straight from flops.
    always_comb
    begin
        logic pop;
        logic placed;
        pop = s.vld[0] & out_ready;
        placed = 1'b0;
        n = s;
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                n.mem[i] = s.mem[i + 1];
                n.vld[i] = s.vld[i + 1];
            end
            n.vld[DEPTH-1] = 1'b0;
        end
        if (in_valid && !s.vld[DEPTH-1])
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (!placed && !n.vld[i])
                begin
                    n.mem[i] = in_data;
                    n.vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= n;
    end

    assign in_ready = !s.vld[DEPTH-1];
    assign out_valid = s.vld[0];
    assign out_data = s.mem[0];

endmodule : ope_sym_buf

// ### verilog/ope_encoder.sv
// What this block does
// - Idle gap of 0 to 256 symbol periods; zero means none.
// - Group count zero: packets repeat while held, gap between packets.
// - Group count nonzero: packets of a group back to back, gap between.
// - Each logical bit spans 1 to 8 symbols, default 4.
// - One symbol gives NRZ, two Manchester, three or more PWM style.
// - Logical one sends programmable pattern, default 1110.
// - Logical zero sends programmable pattern, default 1000.
// - Preamble of 0 to 256 bytes; zero omits it.
// - Preamble byte is 55 or AA hex, default 55.
// - Group mode preamble in every packet or first of group only.
// - Sync word 0 to 32 bits, default 32 bits of 80000000 hex.
// - Identifier field up to 32 bits carrying the configured value.
// - Stop bits 0 to 16 carrying stop value; zero omits them.
// - Key value field 0 to 8 bits, default 4; zero omits it.
// - Scanned matrix or direct keys, direct default, one code per key.
// - Group count 0 to 256; zero disables group mode.
// - Each group holds 1 to 256 packets.
module ope_encoder
    import ope_pkg::*;
#(
    parameter int NUM_KEYS = 8
)(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [OPE_ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [3:0] KEY_N,
    output logic [1:0] SCAN_DRV_N,
    output logic SYM_DATA,
    output logic SYM_GAP,
    output logic SYM_VALID,
    input wire logic SYM_READY,
    output logic BUSY
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr_pend, hready, hresp, en, scan, pre_every, pre_aa;
        logic [OPE_ADDR_W-1:0] wr_addr;
        logic [31:0] hrdata, sync_val, id_val;
        logic [3:0] bit_fmt, key_size;
        logic [7:0] pat1, pat0;
        logic [8:0] gap, tx_cycle, pkt_num, pre_size;
        logic [5:0] sync_size, id_size;
        logic [4:0] stop_size;
        logic [15:0] stop_val;
        logic [NUM_KEYS-1:0][7:0] codes;
        ope_fsm_t st;
        logic [2:0] fld, sym_cnt, key_idx;
        logic [11:0] bit_cnt;
        logic [8:0] gap_cnt, pkt_cnt, grp_cnt;
        logic row;
        logic [1:0] hit, drv_n;
        logic [1:0][1:0] col;
    } ope_state_t;

    ope_state_t s, n;
    logic buf_ready, push;
    logic [1:0] push_data;

    // Lowest pressed key among four active-high lines.
    function automatic logic [1:0] ope_first(input logic [3:0] k);
        ope_first = 2'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (k[i])
                ope_first = i[1:0];
        end
    endfunction : ope_first

    // Field lengths in bits; preamble only when this packet carries one.
    function automatic logic [4:0][11:0] ope_lens(input ope_state_t x);
        logic pre_on;
        pre_on = (x.tx_cycle == 9'h000) || x.pre_every ||
                 (x.pkt_cnt == 9'h000);
        ope_lens[F_PRE] = pre_on ? {x.pre_size, 3'h0} : 12'h000;
        ope_lens[F_SYNC] = {6'h00, x.sync_size};
        ope_lens[F_ID] = {6'h00, x.id_size};
        ope_lens[F_KEY] = {8'h00, x.key_size};
        ope_lens[F_STOP] = {7'h00, x.stop_size};
    endfunction : ope_lens

    // First non-empty field at or after start, or the end marker.
    function automatic logic [2:0] ope_pick(input logic [2:0] start,
                                            input logic [4:0][11:0] lens);
        ope_pick = F_END;
        for (int i = 4; i >= 0; i--)
        begin
            if (i >= int'(start) && lens[i] != 12'h000)
                ope_pick = i[2:0];
        end
    endfunction : ope_pick

    function automatic logic [31:0] ope_read(input ope_state_t x,
                                             input logic [7:0] a);
        ope_read = 32'h0000_0000;
        case (a)
            OFS_CTRL:
            begin
                ope_read[CTRL_EN_BIT] = x.en;
                ope_read[CTRL_SCAN_BIT] = x.scan;
                ope_read[CTRL_PRE_EVERY_BIT] = x.pre_every;
                ope_read[CTRL_PRE_AA_BIT] = x.pre_aa;
            end
            OFS_FORMAT:
            begin
                ope_read[FMT_LSB+:4] = x.bit_fmt;
                ope_read[PAT1_LSB+:8] = x.pat1;
                ope_read[PAT0_LSB+:8] = x.pat0;
            end
            OFS_GAP: ope_read[8:0] = x.gap;
            OFS_REPEAT:
            begin
                ope_read[CYC_LSB+:9] = x.tx_cycle;
                ope_read[PKTN_LSB+:9] = x.pkt_num;
            end
            OFS_PRE_SIZE: ope_read[8:0] = x.pre_size;
            OFS_SYNC_SIZE: ope_read[5:0] = x.sync_size;
            OFS_SYNC_VALUE: ope_read = x.sync_val;
            OFS_ID_SIZE: ope_read[5:0] = x.id_size;
            OFS_ID_VALUE: ope_read = x.id_val;
            OFS_STOP:
            begin
                ope_read[STOP_SZ_LSB+:5] = x.stop_size;
                ope_read[STOP_VAL_LSB+:16] = x.stop_val;
            end
            OFS_KEY_SIZE: ope_read[3:0] = x.key_size;
            OFS_STATUS:
            begin
                ope_read[0] = (x.st != S_IDLE);
                ope_read[3:1] = x.key_idx;
                ope_read[6:4] = x.fld;
                ope_read[8:7] = x.st;
                ope_read[24:16] = x.pkt_cnt;
            end
            default:
            begin
                for (int k = 0; k < NUM_KEYS; k++)
                begin
                    if (a == OFS_CODE_BASE + 8'(4 * k))
                        ope_read[7:0] = x.codes[k];
                end
            end
        endcase
    endfunction : ope_read

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic held, pkt_done, start_pkt, bit_val;
        logic [2:0] cur_idx;
        logic [7:0] pat, pre_byte, key_code;
        logic [2:0] nf;
        logic [8:0] cnt_inc;
        logic [4:0][11:0] lens;
        logic [31:0] wd;
        n = s;
        pkt_done = 1'b0;
        start_pkt = 1'b0;
        bit_val = 1'b0;
        nf = F_END;
        cnt_inc = 9'h000;
        lens = ope_lens(s);
        wd = HWDATA;
        push_data = 2'b00;
        // Register writes land in the data phase.
        if (s.wr_pend)
        begin
            n.wr_pend = 1'b0;
            case (s.wr_addr)
                OFS_CTRL:
                begin
                    n.en = wd[CTRL_EN_BIT];
                    n.scan = wd[CTRL_SCAN_BIT];
                    n.pre_every = wd[CTRL_PRE_EVERY_BIT];
                    n.pre_aa = wd[CTRL_PRE_AA_BIT];
                end
                OFS_FORMAT:
                begin
                    n.bit_fmt = 4'(ope_clamp(32'(wd[FMT_LSB+:4]), MAX_BIT_FMT));
                    if (n.bit_fmt == 4'h0)
                        n.bit_fmt = 4'h1;
                    n.pat1 = wd[PAT1_LSB+:8];
                    n.pat0 = wd[PAT0_LSB+:8];
                end
                OFS_GAP: n.gap = ope_clamp(wd, MAX_COUNT);
                OFS_REPEAT:
                begin
                    n.tx_cycle = ope_clamp(32'(wd[CYC_LSB+:9]), MAX_COUNT);
                    n.pkt_num = ope_clamp(32'(wd[PKTN_LSB+:9]), MAX_COUNT);
                    if (n.pkt_num == 9'h000)
                        n.pkt_num = 9'h001;
                end
                OFS_PRE_SIZE: n.pre_size = ope_clamp(wd, MAX_COUNT);
                OFS_SYNC_SIZE: n.sync_size = 6'(ope_clamp(wd, MAX_WORD_BITS));
                OFS_SYNC_VALUE: n.sync_val = wd;
                OFS_ID_SIZE: n.id_size = 6'(ope_clamp(wd, MAX_WORD_BITS));
                OFS_ID_VALUE: n.id_val = wd;
                OFS_STOP:
                begin
                    n.stop_size = 5'(ope_clamp(32'(wd[STOP_SZ_LSB+:5]),
                                               MAX_STOP_BITS));
                    n.stop_val = wd[STOP_VAL_LSB+:16];
                end
                OFS_KEY_SIZE: n.key_size = 4'(ope_clamp(wd, MAX_KEY_BITS));
                default:
                begin
                    for (int k = 0; k < NUM_KEYS; k++)
                    begin
                        if (s.wr_addr == OFS_CODE_BASE + 8'(4 * k))
                            n.codes[k] = wd[7:0];
                    end
                end
            endcase
        end
        n.row = s.scan ? ~s.row : 1'b0;
        n.drv_n = s.scan ? ~(2'b01 << n.row) : 2'b11;
        n.hit[s.row] = s.scan & (|(~KEY_N));
        n.col[s.row] = ope_first(~KEY_N);
        held = |(~KEY_N);
        cur_idx = {1'b0, ope_first(~KEY_N)};
        if (s.scan)
        begin
            held = |s.hit;
            cur_idx = s.hit[0] ? {1'b0, s.col[0]} : {1'b1, s.col[1]};
        end
        pre_byte = s.pre_aa ? PRE_BYTE_B : PRE_BYTE_A;
        key_code = s.codes[s.key_idx];
        case (s.fld)
            F_PRE: bit_val = pre_byte[s.bit_cnt[2:0]];
            F_SYNC: bit_val = s.sync_val[s.bit_cnt[4:0]];
            F_ID: bit_val = s.id_val[s.bit_cnt[4:0]];
            F_KEY: bit_val = key_code[s.bit_cnt[2:0]];
            default: bit_val = s.stop_val[s.bit_cnt[3:0]];
        endcase
        pat = bit_val ? s.pat1 : s.pat0;
        case (s.st)
            S_IDLE:
            begin
                if (s.en && held)
                begin
                    n.key_idx = cur_idx;
                    n.pkt_cnt = 9'h000;
                    n.grp_cnt = 9'h000;
                    start_pkt = 1'b1;
                end
            end
            S_FIELD:
            begin
                push_data = {1'b0, pat[s.sym_cnt]};
                if (push)
                begin
                    if (s.sym_cnt != 3'h0)
                        n.sym_cnt = s.sym_cnt - 3'h1;
                    else
                    begin
                        n.sym_cnt = s.bit_fmt[2:0] - 3'h1;
                        if (s.bit_cnt != 12'h000)
                            n.bit_cnt = s.bit_cnt - 12'h001;
                        else
                        begin
                            nf = ope_pick(s.fld + 3'h1, lens);
                            if (nf == F_END)
                                pkt_done = 1'b1;
                            else
                            begin
                                n.fld = nf;
                                n.bit_cnt = lens[nf] - 12'h001;
                            end
                        end
                    end
                end
            end
            S_GAP:
            begin
                push_data = 2'b10;
                if (push)
                begin
                    n.gap_cnt = s.gap_cnt - 9'h001;
                    if (s.gap_cnt == 9'h001)
                        start_pkt = 1'b1;
                end
            end
            default: n.st = S_IDLE;
        endcase
        if (pkt_done)
        begin
            if (s.tx_cycle == 9'h000)
            begin
                if (s.en && held && s.gap != 9'h000)
                begin
                    n.st = S_GAP;
                    n.gap_cnt = s.gap;
                end
                else if (s.en && held)
                    start_pkt = 1'b1;
                else
                    n.st = S_IDLE;
            end
            else
            begin
                cnt_inc = s.pkt_cnt + 9'h001;
                if (cnt_inc == s.pkt_num)
                begin
                    n.pkt_cnt = 9'h000;
                    n.grp_cnt = s.grp_cnt + 9'h001;
                    if (n.grp_cnt == s.tx_cycle)
                        n.st = S_IDLE;
                    else if (s.gap != 9'h000)
                    begin
                        n.st = S_GAP;
                        n.gap_cnt = s.gap;
                    end
                    else
                        start_pkt = 1'b1;
                end
                else
                begin
                    n.pkt_cnt = cnt_inc;
                    start_pkt = 1'b1;
                end
            end
        end
        if (start_pkt)
        begin
            // preamble presence follows the packet count
            lens = ope_lens(n);
            nf = ope_pick(F_PRE, lens);
            n.sym_cnt = s.bit_fmt[2:0] - 3'h1;
            if (nf == F_END)
                n.st = S_IDLE;
            else
            begin
                n.st = S_FIELD;
                n.fld = nf;
                n.bit_cnt = lens[nf] - 12'h001;
            end
        end
        // Reads see this cycle's write, so back-to-back access is safe.
        if (HSEL && HTRANS[1] && HREADY)
        begin
            n.wr_pend = HWRITE;
            n.wr_addr = HADDR;
            if (!HWRITE)
                n.hrdata = ope_read(n, HADDR);
        end
    end

    assign push = (s.st == S_FIELD || s.st == S_GAP) && buf_ready;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s <= '0;
            s.hready <= 1'b1;
            s.pre_every <= RST_PRE_EVERY;
            s.bit_fmt <= RST_BIT_FMT;
            s.pat1 <= RST_PAT1;
            s.pat0 <= RST_PAT0;
            s.pkt_num <= RST_PKT_NUM;
            s.sync_size <= RST_SYNC_SIZE;
            s.sync_val <= RST_SYNC_VAL;
            s.key_size <= RST_KEY_SIZE;
            s.drv_n <= 2'b11;
        end
        else
            s <= n;
    end

    // ----------------------------------------------------------------
    // Symbol buffer
    // ----------------------------------------------------------------
    // A stalled modulator holds the encoder here instead of losing a symbol.
    ope_sym_buf #(
        .W(2),
        .DEPTH(2)
    ) u_buf (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .in_valid(s.st == S_FIELD || s.st == S_GAP),
        .in_data(push_data),
        .in_ready(buf_ready),
        .out_valid(SYM_VALID),
        .out_data({SYM_GAP, SYM_DATA}),
        .out_ready(SYM_READY)
    );

    assign HRDATA = s.hrdata;
    assign HREADYOUT = s.hready;
    assign HRESP = s.hresp;
    assign SCAN_DRV_N = s.drv_n;
    assign BUSY = (s.st != S_IDLE);

endmodule : ope_encoder

// ### tb/ope_assertions.sv
module ope_assertions (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [1:0] SCAN_DRV_N,
    input wire logic SYM_DATA,
    input wire logic SYM_GAP,
    input wire logic SYM_VALID,
    input wire logic SYM_READY,
    input wire logic BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    logic [8:0] gap_run_r;
    always_ff @(posedge CLK_SYS or negedge RSTN)
        if (!RSTN)
            gap_run_r <= 9'h000;
        else if (SYM_VALID && SYM_READY)
            gap_run_r <= SYM_GAP ? gap_run_r + 9'h001 : 9'h000;
    chk_gap_run: assert property (gap_run_r <= 9'h100)
        else $error("gap too long");
    chk_gap_level: assert property (SYM_VALID && SYM_GAP |-> !SYM_DATA)
        else $error("gap symbol high");
    chk_stall_hold: assert property (SYM_VALID && !SYM_READY |=>
        SYM_VALID && $stable({SYM_DATA, SYM_GAP})) else $error("symbol lost");
    chk_idle_quiet: assert property (!BUSY && !SYM_VALID |=> !SYM_VALID)
        else $error("symbol while idle");
    chk_scan_one: assert property (SCAN_DRV_N != 2'b00)
        else $error("two rows driven");
    chk_scan_alt: assert property (SCAN_DRV_N == 2'b10 |=>
        SCAN_DRV_N != 2'b10) else $error("row stuck");
    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus stalled");
    chk_rdata_hold: assert property (!(HSEL && HTRANS[1] && HREADY &&
        !HWRITE) |=> $stable(HRDATA)) else $error("read data moved");
    cov_gap: cover property (SYM_VALID && SYM_READY && SYM_GAP);
    cov_stall: cover property (SYM_VALID && !SYM_READY ##1 SYM_READY);
    cov_scan: cover property (SCAN_DRV_N == 2'b01);
endmodule : ope_assertions

bind ope_encoder ope_assertions u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SCAN_DRV_N(SCAN_DRV_N), .SYM_DATA(SYM_DATA), .SYM_GAP(SYM_GAP),
    .SYM_VALID(SYM_VALID), .SYM_READY(SYM_READY), .BUSY(BUSY));

// ### tb/ope_sym_sink.sv
module ope_sym_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall_en,
    input wire logic sym_valid,
    input wire logic sym_data,
    input wire logic sym_gap,
    output logic sym_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic [1:0] cap[$];
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            cnt_r <= 4'h0;
            sym_ready <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 4'h1;
            sym_ready <= !(stall_en && cnt_r < 4'h6);
            if (sym_valid && sym_ready)
                cap.push_back({sym_gap, sym_data});
        end
endmodule : ope_sym_sink

// ### tb/tb_ook_packet_encoder.sv
module tb_ook_packet_encoder
    import ope_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, press = 1'b0;
    logic stall = 1'b0, scan = 1'b0;
    logic pe, pa, hrdy, hresp, valid, sdata, sgap, ready, busy;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'h75AA;
    logic [31:0] hrdata, rd, syv, idv, stv, code;
    logic [1:0] scan_n, exq[$], cap[$];
    logic [7:0] p1, p0;
    logic [3:0] key_n;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0, row = 0, col = 0;
    int fmt, gap, pre, sys, ids, ks, sts;
    // A scanned column reads low only while its row is driven.
    assign key_n = (!press || (scan && scan_n[row])) ? 4'hF : ~(4'h1 << col);
    initial
        forever #2 clk = ~clk;
    ope_encoder dut (.CLK_SYS(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .KEY_N(key_n), .SCAN_DRV_N(scan_n), .SYM_DATA(sdata), .SYM_GAP(sgap),
        .SYM_VALID(valid), .SYM_READY(ready), .BUSY(busy));
    ope_sym_sink sink (.clk(clk), .rst_n(rstn), .stall_en(stall),
        .sym_valid(valid), .sym_data(sdata), .sym_gap(sgap), .sym_ready(ready));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            miscompares++;
            conclude();
        end
    end
    function automatic int rnd(input int m);
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C1_1DB7 : 32'h0);
        return (m < 0) ? seed : seed % (m + 1);
    endfunction : rnd
    function automatic int pick(input int i, input int m);
        return (i == 1) ? 0 : (i == 2) ? m : rnd(m);
    endfunction : pick
    function automatic void add(input logic [31:0] v, input int n);
        for (int b = n - 1; b >= 0; b--)
            for (int s = fmt - 1; s >= 0; s--)
                exq.push_back({1'b0, v[b] ? p1[s] : p0[s]});
    endfunction : add
    function automatic void build(input int g, input int p);
        exq.delete();
        for (int i = 0; i < g; i++)
        begin
            if (i > 0)
                repeat (gap) exq.push_back(2'h2);
            for (int j = 0; j < p; j++)
            begin
                if (pe || j == 0)
                    repeat (pre) add(pa ? 32'hAA : 32'h55, 8);
                add(syv, sys);
                add(idv, ids);
                add(code, ks);
                add(stv, sts);
            end
        end
    endfunction : build
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 0);
        checked++;
        if (rd !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t reg %h is %h not %h", $time, a, rd, e);
        end
    endtask : chk_reg
    task automatic chk_stream();
        int bad;
        bad = (cap.size() != exq.size());
        foreach (exq[i])
            bad = bad | (i < cap.size() && cap[i] !== exq[i]);
        checked++;
        if (bad)
        begin
            miscompares++;
            $display("[FAIL] %0t stream of %0d symbols", $time, cap.size());
        end
    endtask : chk_stream
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic run(input int i);
        int g, p, k;
        fmt = (i == 3) ? 8 : i + 1;
        p1 = 8'(rnd(255));
        p0 = 8'(rnd(255));
        pre = pick(i, 2);
        sys = pick(i, 32);
        ids = pick(i, 32);
        ks = pick(i, 8);
        sts = pick(i, 16);
        gap = pick(i, 256);
        syv = rnd(-1);
        idv = rnd(-1);
        stv = rnd(65535);
        code = rnd(255);
        g = (i == 0) ? 0 : (i == 2) ? 3 : 1 + rnd(2);
        p = 1 + rnd(2);
        pe = (i != 3) && rnd(1);
        pa = 1'(rnd(1));
        scan = (i == 3);
        row = rnd(1);
        col = rnd(3);
        k = scan ? 4 * row + col : col;
        bus(1'b1, OFS_FORMAT, {8'h00, p0, p1, 4'h0, 4'(fmt)});
        bus(1'b1, OFS_GAP, gap);
        bus(1'b1, OFS_REPEAT, {7'h0, 9'(p), 7'h0, 9'(g)});
        bus(1'b1, OFS_PRE_SIZE, pre);
        bus(1'b1, OFS_SYNC_SIZE, sys);
        bus(1'b1, OFS_SYNC_VALUE, syv);
        bus(1'b1, OFS_ID_SIZE, ids);
        bus(1'b1, OFS_ID_VALUE, idv);
        bus(1'b1, OFS_STOP, {stv[15:0], 11'h0, 5'(sts)});
        bus(1'b1, OFS_KEY_SIZE, ks);
        bus(1'b1, OFS_CODE_BASE + 8'(4 * k), code);
        bus(1'b1, OFS_CTRL, {28'h0, pa, pe, scan, 1'b1});
        sink.cap.delete();
        @(posedge clk);
        press <= 1'b1;
        stall <= 1'(rnd(1));
        repeat (8) @(posedge clk);
        build(1, 1);
        while (g == 0 && sink.cap.size() <= exq.size() + gap) @(posedge clk);
        press <= 1'b0;
        while (busy !== 1'b0 || valid !== 1'b0) @(posedge clk);
        cap = sink.cap;
        while (cap.size() > 0 && cap[$][1] === 1'b1) void'(cap.pop_back());
        for (int n = 1; n < 60; n++)
        begin
            build(g == 0 ? n : g, g == 0 ? 1 : p);
            if (g > 0 || exq.size() >= cap.size())
                break;
        end
        chk_stream();
    endtask : run
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        chk_reg(OFS_FORMAT, 32'h0008_0E04);
        chk_reg(OFS_SYNC_SIZE, 32'h20);
        chk_reg(OFS_SYNC_VALUE, 32'h8000_0000);
        chk_reg(OFS_KEY_SIZE, 32'h4);
        chk_reg(OFS_CTRL, 32'h4);
        chk_reg(8'h30, 32'h0);
        bus(1'b1, OFS_REPEAT, 32'h0000_01FF);
        chk_reg(OFS_REPEAT, 32'h0001_0100);
        for (int i = 0; i < 4; i++)
            run(i);
        conclude();
    end
endmodule : tb_ook_packet_encoder
